// ### rtl/iam_pkg.sv
// shared constants and types of the interrupt auto-mask and cause block
package iam_pkg;
   // bus geometry
   localparam int          ADDR_W         = 16;
   localparam int          SCR_W          = 11;
   // register byte offsets
   localparam logic [15:0] OFF_SCR        = 16'h1500; // secondary cause, read/write-one clear
   localparam logic [15:0] OFF_LMASK_SET  = 16'h1508; // legacy mask set / read
   localparam logic [15:0] OFF_LMASK_CLR  = 16'h150C; // legacy mask clear
   localparam logic [15:0] OFF_MISSED     = 16'h1510; // missed packet counter
   localparam logic [15:0] OFF_CFG        = 16'h1514; // general configuration
   localparam logic [15:0] OFF_CAUSE_SET  = 16'h1520; // extended cause set
   localparam logic [15:0] OFF_MASK_SET   = 16'h1524; // extended mask set / read
   localparam logic [15:0] OFF_MASK_CLR   = 16'h1528; // extended mask clear
   localparam logic [15:0] OFF_AUTO_MASK  = 16'h1530; // auto-mask enable
   localparam logic [15:0] OFF_EXT_CAUSE  = 16'h1580; // extended cause, read/write-one clear
   // configuration fields
   localparam int          CFG_MULTI_VEC  = 0;
   localparam int          CFG_GLOBAL_AM  = 1;
   localparam int          CFG_MSI_SINGLE = 2;
   localparam int          CFG_COR_DIS    = 3;
   localparam int          CFG_SOFT_RST   = 4;
   // extended cause fields
   localparam int          EXT_TIMER      = 30;
   localparam int          EXT_OTHER      = 31;
   localparam logic [31:0] EXT_MASK_NMV   = 32'hC000000F; // queues 3:0, timer, other
   localparam logic [31:0] EXT_MASK_MV    = 32'h0000001F; // vectors 4:0
   // secondary cause fields
   localparam int          SC_TX_WB       = 0;
   localparam int          SC_LINK        = 2;
   localparam int          SC_RX_LOW      = 4;
   localparam int          SC_RX_MISS     = 6;
   localparam int          SC_RX_WB       = 7;
   localparam int          SC_PHY         = 10;
   // values after reset
   localparam logic [31:0] MASK_RST       = 32'h80000000;
   localparam logic [31:0] AUTO_MASK_RST  = 32'h00000000;
   localparam logic [4:0]  CFG_RST        = 5'h00;
   // axi response codes
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // hardware events, all one-cycle pulses on the system clock
   typedef struct packed {
      logic       tx_writeback;
      logic       rx_writeback;
      logic       rx_low_desc;
      logic       rx_overflow;
      logic       phy_irq;
      logic       tcp_timer;
      logic [4:0] queue;
      logic       msg_sent;
   } iam_event_t;

   // decoded register write, data already qualified by byte strobes
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       data;
      logic [31:0]       bmask;
   } iam_wreq_t;
endpackage : iam_pkg

// ### rtl/iam_link_sync.sv
// link indication synchroniser and change detector
module iam_link_sync
   import iam_pkg::*;
(
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_reset,
   // asynchronous link level from the phy
   input  wire logic i_link_up,
   // one-cycle pulse on every link change
   output logic      o_change
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // two flops; the first is read only by the second
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= i_link_up;
         sync_q <= meta_q;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         last_q   <= 1'b0;
         o_change <= 1'b0;
      end else begin
         last_q   <= sync_q;
         o_change <= sync_q ^ last_q;
      end
   end
endmodule : iam_link_sync

// ### rtl/iam_axil_slave.sv
// axi4-lite slave front end, one write and one read at a time
module iam_axil_slave
   import iam_pkg::*;
(
   // clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_reset,
   // write address and data
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   // write response
   output logic                   o_bvalid,
   output logic [1:0]             o_bresp,
   input  wire logic              i_bready,
   // read address and data
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic                   o_rvalid,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   input  wire logic              i_rready,
   // register side
   output logic                   o_wr_go,
   output iam_wreq_t              o_wreq,
   input  wire logic              i_wr_hit,
   output logic                   o_rd_go,
   output logic [ADDR_W-1:0]      o_rd_addr,
   input  wire logic [31:0]       i_rd_data,
   input  wire logic              i_rd_hit
);
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;

   // write fires once both halves are held and no response is pending
   assign o_wr_go   = ~o_awready & ~o_wready & ~o_bvalid;
   assign o_rd_go   = i_arvalid & o_arready;
   assign o_rd_addr = i_araddr;

   always_comb begin
      o_wreq.addr  = awaddr_q;
      o_wreq.bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
      o_wreq.data  = wdata_q & o_wreq.bmask;
   end

   // write channels, taken in either order
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         if (i_awvalid && o_awready) begin
            o_awready <= 1'b0;
            awaddr_q  <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            o_wready <= 1'b0;
            wdata_q  <= i_wdata;
            wstrb_q  <= i_wstrb;
         end
         if (o_wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= i_wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   // read channel; data captured at the address handshake
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= '0;
         o_rresp   <= RESP_OKAY;
      end else if (o_rd_go) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= i_rd_data;
         o_rresp   <= i_rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end
endmodule : iam_axil_slave

// ### rtl/iam_top.sv
// interrupt auto-mask, extended cause and secondary cause logic
module iam_top
   import iam_pkg::*;
(
   // clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_reset,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output logic                   o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output logic                   o_wready,
   // axi4-lite write response
   output logic                   o_bvalid,
   output logic [1:0]             o_bresp,
   input  wire logic              i_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output logic                   o_arready,
   output logic                   o_rvalid,
   output logic [31:0]            o_rdata,
   output logic [1:0]             o_rresp,
   input  wire logic              i_rready,
   // device events and phy link level
   input  iam_event_t             i_event,
   input  wire logic              i_link_up,
   // interrupt request towards the message engine
   output logic                   o_irq
);
   // bus side
   logic              wr_go;
   iam_wreq_t         wreq;
   logic              wr_hit;
   logic              rd_go;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0]       rd_data;
   logic              rd_hit;
   // state
   logic [30:0]       ext_cause_q;
   logic [30:0]       ext_cause_d;
   logic [31:0]       mask_q;
   logic [31:0]       mask_d;
   logic [31:0]       auto_mask_q;
   logic [SCR_W-1:0]  scr_q;
   logic [SCR_W-1:0]  lmask_q;
   logic [31:0]       missed_q;
   logic [4:0]        cfg_q;
   // derived
   logic              link_change;
   logic              multi_vec;
   logic              soft_rst;
   logic [31:0]       ext_valid;
   logic [31:0]       ext_view;
   logic [31:0]       ext_set;
   logic [31:0]       ext_clr;
   logic [31:0]       wd;
   logic [SCR_W-1:0]  scr_event;
   logic [SCR_W-1:0]  scr_clr;
   logic              other_cause;

   // bus slave front end
   iam_axil_slave u_bus (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_awaddr  (i_awaddr),
      .i_awvalid (i_awvalid),
      .o_awready (o_awready),
      .i_wdata   (i_wdata),
      .i_wstrb   (i_wstrb),
      .i_wvalid  (i_wvalid),
      .o_wready  (o_wready),
      .o_bvalid  (o_bvalid),
      .o_bresp   (o_bresp),
      .i_bready  (i_bready),
      .i_araddr  (i_araddr),
      .i_arvalid (i_arvalid),
      .o_arready (o_arready),
      .o_rvalid  (o_rvalid),
      .o_rdata   (o_rdata),
      .o_rresp   (o_rresp),
      .i_rready  (i_rready),
      .o_wr_go   (wr_go),
      .o_wreq    (wreq),
      .i_wr_hit  (wr_hit),
      .o_rd_go   (rd_go),
      .o_rd_addr (rd_addr),
      .i_rd_data (rd_data),
      .i_rd_hit  (rd_hit)
   );

   // link level arrives from another domain, so it is synchronised there
   iam_link_sync u_link (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_link_up (i_link_up),
      .o_change  (link_change)
   );

   // write strobes per register
   logic w_scr, w_lset, w_lclr, w_cfg, w_cset, w_mset, w_mclr, w_am, w_ecr;
   logic r_scr, r_ecr;

   assign wd     = wreq.data;
   assign w_scr  = wr_go && (wreq.addr == OFF_SCR);
   assign w_lset = wr_go && (wreq.addr == OFF_LMASK_SET);
   assign w_lclr = wr_go && (wreq.addr == OFF_LMASK_CLR);
   assign w_cfg  = wr_go && (wreq.addr == OFF_CFG);
   assign w_cset = wr_go && (wreq.addr == OFF_CAUSE_SET);
   assign w_mset = wr_go && (wreq.addr == OFF_MASK_SET);
   assign w_mclr = wr_go && (wreq.addr == OFF_MASK_CLR);
   assign w_am   = wr_go && (wreq.addr == OFF_AUTO_MASK);
   assign w_ecr  = wr_go && (wreq.addr == OFF_EXT_CAUSE);
   assign r_scr  = rd_go && (rd_addr == OFF_SCR);
   assign r_ecr  = rd_go && (rd_addr == OFF_EXT_CAUSE);

   // the missed counter is read-only, so a write there is refused
   always_comb begin
      case (wreq.addr)
         OFF_SCR, OFF_LMASK_SET, OFF_LMASK_CLR, OFF_CFG, OFF_CAUSE_SET,
         OFF_MASK_SET, OFF_MASK_CLR, OFF_AUTO_MASK, OFF_EXT_CAUSE: wr_hit = 1'b1;
         default:                                                 wr_hit = 1'b0;
      endcase
   end

   // mode decode; soft reset is a self-clearing pulse
   assign multi_vec = cfg_q[CFG_MULTI_VEC];
   assign soft_rst  = w_cfg && wd[CFG_SOFT_RST];

   assign ext_valid = multi_vec ? EXT_MASK_MV : EXT_MASK_NMV;

   // falls with the last unmasked cause
   assign other_cause = ~multi_vec & (|(scr_q & lmask_q));
   assign ext_view    = {other_cause, ext_cause_q} & ext_valid;

   // hardware cause sources move with the mode's layout
   always_comb begin
      ext_set = '0;
      if (multi_vec) begin
         ext_set[4:0] = i_event.queue;
      end else begin
         ext_set[3:0]      = i_event.queue[3:0];
         ext_set[EXT_TIMER] = i_event.tcp_timer;
      end
      if (w_cset) begin
         ext_set = ext_set | (wd & ext_valid);
      end
   end

   // read-to-clear and write-one-to-clear of the extended cause
   always_comb begin
      ext_clr = '0;
      if (r_ecr) begin
         ext_clr = ext_view;
      end
      if (w_ecr) begin
         ext_clr = ext_clr | (wd & ext_valid);
      end
   end

   // set wins over a clear in the same cycle
   assign ext_cause_d = ((ext_cause_q & ~ext_clr[30:0]) | ext_set[30:0]) & ext_valid[30:0];

   // extended cause store; the other bit is never stored, only derived
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || soft_rst) begin
         ext_cause_q <= '0;
      end else begin
         ext_cause_q <= ext_cause_d;
      end
   end

   // extended mask next value, clears first and software sets last
   always_comb begin
      mask_d = mask_q;
      if (i_event.msg_sent && !multi_vec && cfg_q[CFG_MSI_SINGLE] && (|auto_mask_q)) begin
         mask_d = '0;
      end else if (i_event.msg_sent && multi_vec && cfg_q[CFG_GLOBAL_AM]) begin
         mask_d = mask_d & ~auto_mask_q;
      end
      mask_d = mask_d & ~(auto_mask_q & ext_clr);
      if (w_mclr) begin
         mask_d = mask_d & ~wd;
      end
      if (w_mset) begin
         mask_d = mask_d | wd;
      end
      if (w_cset) begin
         mask_d = mask_d | (wd & auto_mask_q);
      end
      mask_d = mask_d & ext_valid;
   end

   // mask survives soft reset, only the hard reset restores it
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         mask_q <= MASK_RST;
      end else begin
         mask_q <= mask_d;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         auto_mask_q <= AUTO_MASK_RST;
      end else if (w_am) begin
         auto_mask_q <= ((auto_mask_q & ~wreq.bmask) | wd) & ext_valid;
      end
   end

   // secondary cause sources in their bit positions
   always_comb begin
      scr_event = '0;
      scr_event[SC_TX_WB]   = i_event.tx_writeback;
      scr_event[SC_LINK]    = link_change;
      scr_event[SC_RX_LOW]  = i_event.rx_low_desc;
      scr_event[SC_RX_MISS] = i_event.rx_overflow;
      scr_event[SC_RX_WB]   = i_event.rx_writeback;
      scr_event[SC_PHY]     = i_event.phy_irq;
   end

   assign scr_clr = ({SCR_W{r_scr & ~cfg_q[CFG_COR_DIS]}}) | ({SCR_W{w_scr}} & wd[SCR_W-1:0]);

   generate
      for (genvar b = 0; b < SCR_W; b++) begin : g_scr
         always_ff @(posedge i_sys_clk) begin
            if (i_reset || soft_rst) begin
               scr_q[b] <= 1'b0;
            end else if (scr_event[b]) begin
               scr_q[b] <= 1'b1;
            end else if (scr_clr[b]) begin
               scr_q[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // legacy mask of the secondary causes; link change starts masked
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || soft_rst) begin
         lmask_q <= '0;
      end else if (w_lset) begin
         lmask_q <= lmask_q | wd[SCR_W-1:0];
      end else if (w_lclr) begin
         lmask_q <= lmask_q & ~wd[SCR_W-1:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset || soft_rst) begin
         missed_q <= '0;
      end else if (i_event.rx_overflow) begin
         missed_q <= missed_q + 32'h00000001;
      end
   end

   // configuration; the soft reset bit never stores
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || soft_rst) begin
         cfg_q <= CFG_RST;
      end else if (w_cfg) begin
         cfg_q <= ((cfg_q & ~wreq.bmask[4:0]) | wd[4:0]) & ~(5'h01 << CFG_SOFT_RST);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(ext_view & mask_q);
      end
   end

   // read multiplexer; clear-type registers return their value before clearing
   always_comb begin
      rd_data = '0;
      rd_hit  = 1'b1;
      case (rd_addr)
         OFF_SCR:       rd_data[SCR_W-1:0] = scr_q;
         OFF_LMASK_SET: rd_data[SCR_W-1:0] = lmask_q;
         OFF_MISSED:    rd_data = missed_q;
         OFF_CFG:       rd_data[4:0] = cfg_q;
         OFF_MASK_SET:  rd_data = mask_q;
         OFF_AUTO_MASK: rd_data = auto_mask_q & ext_valid;
         OFF_EXT_CAUSE: rd_data = ext_view;
         // write-only registers read as zero
         OFF_LMASK_CLR, OFF_CAUSE_SET, OFF_MASK_CLR: rd_data = '0;
         default:       rd_hit = 1'b0;
      endcase
   end
endmodule : iam_top

// ### tb/iam_chk.sv
// port-level assertion checker for the interrupt auto-mask block
module iam_chk
   import iam_pkg::*;
(
   // clock and reset
   input wire logic        i_sys_clk,
   input wire logic        i_reset,
   // bus handshakes
   input wire logic        i_awvalid,
   input wire logic        o_awready,
   input wire logic        i_wvalid,
   input wire logic        o_wready,
   input wire logic        o_bvalid,
   input wire logic        i_arvalid,
   input wire logic        o_arready,
   input wire logic        o_rvalid,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0]  o_rresp,
   input wire logic        i_rready,
   // events and interrupt
   input iam_event_t       i_event,
   input wire logic        i_link_up,
   input wire logic        o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] idle_q;
   logic       link_q;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   // quiet cycles since any event, link edge or bus request; saturates so it never wraps
   always_ff @(posedge i_sys_clk) begin
      link_q <= i_link_up;
      if (i_reset || (|i_event) || (link_q != i_link_up) || i_awvalid || i_arvalid) begin
         idle_q <= 4'h0;
      end else if (idle_q != 4'hF) begin
         idle_q <= idle_q + 4'h1;
      end
   end

   a_irq_reset: assert property ($past(i_reset) |-> !o_irq)
      else $error("irq high after reset");
   a_irq_rise_cause: assert property ($rose(o_irq) |-> idle_q < 4'hA)
      else $error("irq rose with no cause");
   a_irq_fall_clear: assert property ($fell(o_irq) |-> idle_q < 4'hA)
      else $error("irq fell with no clear");
   a_aw_refuse: assert property (i_awvalid && o_awready |=> !o_awready)
      else $error("second write accepted");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
      else $error("write answer late");
   a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   a_rvalid_drop: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
      else $error("read answer not released");
   a_slverr_zero: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h0)
      else $error("error read with data");

   c_irq: cover property ($rose(o_irq));
   c_slverr: cover property (o_rvalid && o_rresp == RESP_SLVERR);
   c_msg: cover property (i_event.msg_sent && o_irq);
endmodule : iam_chk

bind iam_top iam_chk i_chk (.*);

// ### tb/iam_msg_model.sv
// message engine model: sends one message some cycles after each irq rise
module iam_msg_model
   import iam_pkg::*;
#(
   parameter int DLY = 3
)
(
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_reset,
   // request in, message-sent pulse out
   input  wire logic i_irq,
   output logic      o_msg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       irq_q;
   logic [3:0] cnt_q;

   // delay models moderation; a level irq only triggers once per rise
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         irq_q <= 1'b0;
         cnt_q <= 4'h0;
         o_msg <= 1'b0;
      end else begin
         irq_q <= i_irq;
         o_msg <= (cnt_q == 4'h1);
         if (i_irq && !irq_q) begin
            cnt_q <= 4'(DLY);
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule : iam_msg_model

// ### tb/interrupt_auto_mask_and_cause_tb.sv
// self-checking bench for the interrupt auto-mask block
module interrupt_auto_mask_and_cause_tb
   import iam_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              i_sys_clk, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_link_up, msg;
   logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   logic [ADDR_W-1:0] i_awaddr, i_araddr;
   logic [31:0]       i_wdata, o_rdata;
   logic [3:0]        i_wstrb;
   logic [1:0]        o_bresp, o_rresp;
   logic [10:0]       evb;
   iam_event_t        i_event;
   int                fail_count, num_checks, cyc;

   // bench events above, message pulse from the model in bit 0
   assign i_event = iam_event_t'({evb, msg});
   iam_top i_iam_top (.*);
   iam_msg_model #(.DLY(3)) i_iam_msg_model (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_irq(o_irq), .o_msg(msg));

   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end

   // hang guard, well above the length of the sequence
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count = fail_count + 1;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks = num_checks + 1;
      if (s !== e) begin
         fail_count = fail_count + 1;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_sys_clk);
      i_awaddr  <= a;
      i_wdata   <= d;
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      i_bready  <= 1'b1;
      do begin
         @(posedge i_sys_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
      chk(32'(o_bresp), 32'(er));
   endtask : wr

   // rready rises with the request and holds until the answer is sampled; data taken at that edge
   task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge i_sys_clk);
      i_araddr  <= a;
      i_arvalid <= 1'b1;
      i_rready  <= 1'b1;
      do begin
         @(posedge i_sys_clk);
         if (o_arready) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
      chk(o_rdata, e);
      chk(32'(o_rresp), 32'(er));
   endtask : rd

   task automatic pulse(input logic [10:0] v);
      @(posedge i_sys_clk);
      evb <= v;
      @(posedge i_sys_clk);
      evb <= 11'h000;
      repeat (3) @(posedge i_sys_clk);
   endtask : pulse

   task automatic t_layout;
      rd(OFF_AUTO_MASK, 32'h00000000, RESP_OKAY);
      rd(16'h1504, 32'h00000000, RESP_SLVERR);
      wr(16'h15FC, 32'h00000001, RESP_SLVERR);
      wr(OFF_AUTO_MASK, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFF_AUTO_MASK, 32'hC000000F, RESP_OKAY);
      wr(OFF_CFG, 32'h00000010, RESP_OKAY);
      rd(OFF_AUTO_MASK, 32'hC000000F, RESP_OKAY);
      wr(OFF_CFG, 32'h00000001, RESP_OKAY);
      wr(OFF_AUTO_MASK, 32'hFFFFFFFF, RESP_OKAY);
      rd(OFF_AUTO_MASK, 32'h0000001F, RESP_OKAY);
      wr(OFF_AUTO_MASK, 32'h00000000, RESP_OKAY);
      wr(OFF_CFG, 32'h00000000, RESP_OKAY);
      // vector mode dropped the other-cause mask bit, so give it back
      wr(OFF_MASK_SET, 32'h80000000, RESP_OKAY);
      rd(OFF_MASK_SET, 32'h80000000, RESP_OKAY);
      $display("t_layout done");
   endtask : t_layout

   task automatic t_events;
      logic [10:0] ev [5] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040};
      logic [31:0] ex [5] = '{32'h001, 32'h080, 32'h010, 32'h040, 32'h400};
      for (int k = 0; k < 5; k++) begin
         pulse(ev[k]);
         rd(OFF_SCR, ex[k], RESP_OKAY);
      end
      rd(OFF_SCR, 32'h0, RESP_OKAY);
      rd(OFF_MISSED, 32'h1, RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
         @(posedge i_sys_clk);
         i_link_up <= ~i_link_up;
         repeat (8) @(posedge i_sys_clk);
         rd(OFF_SCR, 32'h4, RESP_OKAY);
      end
      // event lands on the clearing edge
      fork
         wr(OFF_SCR, 32'h1, RESP_OKAY);
         begin
            // one edge late so the pulse meets the write's register edge
            @(posedge i_sys_clk);
            pulse(11'h400);
         end
      join
      rd(OFF_SCR, 32'h1, RESP_OKAY);
      $display("t_events done");
   endtask : t_events

   task automatic t_other;
      wr(OFF_LMASK_SET, 32'h1, RESP_OKAY);
      pulse(11'h400);
      chk(32'(o_irq), 32'h1);
      repeat (6) @(posedge i_sys_clk);
      rd(OFF_EXT_CAUSE, 32'h80000000, RESP_OKAY);
      wr(OFF_CFG, 32'h8, RESP_OKAY);
      rd(OFF_SCR, 32'h1, RESP_OKAY);
      rd(OFF_SCR, 32'h1, RESP_OKAY);
      wr(OFF_SCR, 32'h1, RESP_OKAY);
      rd(OFF_EXT_CAUSE, 32'h0, RESP_OKAY);
      chk(32'(o_irq), 32'h0);
      wr(OFF_CFG, 32'h0, RESP_OKAY);
      // timer and queue 0 causes land in bits 30 and 0
      pulse(11'h021);
      rd(OFF_EXT_CAUSE, 32'h40000001, RESP_OKAY);
      rd(OFF_EXT_CAUSE, 32'h00000000, RESP_OKAY);
      $display("t_other done");
   endtask : t_other

   task automatic t_mask;
      wr(OFF_AUTO_MASK, 32'h1, RESP_OKAY);
      wr(OFF_CAUSE_SET, 32'h1, RESP_OKAY);
      rd(OFF_MASK_SET, 32'h80000001, RESP_OKAY);
      wr(OFF_EXT_CAUSE, 32'h1, RESP_OKAY);
      rd(OFF_MASK_SET, 32'h80000000, RESP_OKAY);
      wr(OFF_MASK_CLR, 32'h80000000, RESP_OKAY);
      wr(OFF_MASK_SET, 32'h3, RESP_OKAY);
      wr(OFF_MASK_CLR, 32'h1, RESP_OKAY);
      rd(OFF_MASK_SET, 32'h2, RESP_OKAY);
      $display("t_mask done");
   endtask : t_mask

   task automatic t_modes;
      wr(OFF_CFG, 32'h3, RESP_OKAY);
      wr(OFF_MASK_SET, 32'h3, RESP_OKAY);
      wr(OFF_CAUSE_SET, 32'h2, RESP_OKAY);
      repeat (10) @(posedge i_sys_clk);
      rd(OFF_MASK_SET, 32'h2, RESP_OKAY);
      wr(OFF_EXT_CAUSE, 32'h1F, RESP_OKAY);
      wr(OFF_CFG, 32'h4, RESP_OKAY);
      wr(OFF_CAUSE_SET, 32'h2, RESP_OKAY);
      repeat (10) @(posedge i_sys_clk);
      rd(OFF_MASK_SET, 32'h0, RESP_OKAY);
      $display("t_modes done");
   endtask : t_modes

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict

   initial begin
      {i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_link_up} = 7'h01 << 6;
      {i_awaddr, i_araddr, i_wdata, evb} = '0;
      i_wstrb = 4'hF;
      repeat (3) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      t_layout();
      t_events();
      t_other();
      t_mask();
      t_modes();
      print_verdict();
   end
endmodule : interrupt_auto_mask_and_cause_tb
